// File: hdl/ctmc_pkg.sv
// package for the transceiver mode controller: modes, timing counts, port bundles
// Function
// - regulator output floats only in sleep
// - bus monitoring continues during sleep
// - bus dominant or wake edge exits sleep
// - wakeup drives regulator output high again
// - wakeup flag shown on fault and receive
// - standby and sleep terminate bus to ground
// - sleep only via held go-to-sleep command or core/io undervoltage
// - go-to-sleep command disables transmitter immediately
// - simultaneous wakeup beats go-to-sleep command
// - after undervoltage in sleep, ignore select pins
// - core or io undervoltage forces sleep unless battery undervoltage is also present
// - bus failure flag after fourth transmit release
// - listen-only shows power-on flag after low power
// - select encoding: 11 normal, 10 listen, 00 standby
// - listen-only ignores transmit, still receives
// - battery undervoltage forces standby
// - wake edge of either polarity, filtered
package ctmc_pkg;
	localparam int CLK_HZ = 20000000;
	localparam int SLEEP_HOLD_NS = 50000;
	localparam int WAKE_FILT_NS = 50000;
	localparam int DOM_MIN_NS = 4000;
	localparam int CLK_NS = 1000000000 / CLK_HZ;
	localparam int SLEEP_HOLD_CYC = SLEEP_HOLD_NS / CLK_NS;
	localparam int WAKE_FILT_CYC = WAKE_FILT_NS / CLK_NS;
	localparam int DOM_MIN_CYC = (DOM_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int SEL_STABLE_CYC = 2;
	localparam int REL_COUNT = 4;
	localparam int CNT_W = 12;

	typedef enum logic [2:0] {
		CTMC_NORMAL = 3'h0,
		CTMC_LISTEN = 3'h1,
		CTMC_STANDBY = 3'h2,
		CTMC_GOSLEEP = 3'h3,
		CTMC_SLEEP = 3'h4
	} ctmc_mode_t;

	typedef struct packed {
		logic vcc_uv;
		logic vio_uv;
		logic vbat_uv;
	} ctmc_supply_t;

	typedef struct packed {
		logic bus_dominant;
		logic bus_rx;
		logic bus_fail;
		logic local_fail;
	} ctmc_bus_t;
endpackage

// File: hdl/ctmc_mode_control.sv
// operating-mode, sleep and wakeup controller of the transceiver
`timescale 1ns/1ps
module ctmc_mode_control
	import ctmc_pkg::*;
#(
	parameter int HOLD_CYC = SLEEP_HOLD_CYC,
	parameter int FILT_CYC = WAKE_FILT_CYC
)(
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic mode_select_a_i,
	input wire logic mode_select_b_i,
	input wire logic txd_i,
	input wire logic wake_i,
	input wire ctmc_supply_t supply_i,
	input wire ctmc_bus_t bus_i,
	output logic tx_enable_o,
	output logic tx_data_o,
	output logic rxd_o,
	output logic fault_flag_out_o,
	output logic regulator_control_out_o,
	output logic regulator_control_oe_o,
	output logic bus_bias_half_o,
	output logic [2:0] mode_o
);
	ctmc_mode_t mode_r, mode_nxt;
	logic [1:0] sel_last_r, sel_last_nxt, sel_r, sel_nxt;
	logic [CNT_W-1:0] sel_cnt_r, sel_cnt_nxt, hold_r, hold_nxt, filt_r, filt_nxt;
	logic [CNT_W-1:0] dom_r, dom_nxt;
	logic [2:0] rel_r, rel_nxt;
	logic wake_lvl_r, wake_lvl_nxt, wake_flag_r, wake_flag_nxt, lock_r, lock_nxt;
	logic pwon_r, pwon_nxt, txd_q_r, txd_q_nxt;
	logic tx_en_nxt, tx_d_nxt, rxd_nxt, fault_nxt, reg_nxt, bias_nxt;
	logic wake_ev, local_wake, core_uv;

	function automatic logic low_power(input ctmc_mode_t m);
		return (m == CTMC_STANDBY) || (m == CTMC_GOSLEEP) || (m == CTMC_SLEEP);
	endfunction

	always_comb
	begin
		core_uv = supply_i.vcc_uv | supply_i.vio_uv;
		sel_last_nxt = {mode_select_a_i, mode_select_b_i};
		sel_cnt_nxt = sel_cnt_r;
		sel_nxt = sel_r;
		// a select change must settle before the decoder reacts
		if (sel_last_nxt != sel_last_r)
			sel_cnt_nxt = '0;
		else if (sel_cnt_r < CNT_W'(SEL_STABLE_CYC))
			sel_cnt_nxt = sel_cnt_r + 1'b1;
		else
			sel_nxt = sel_last_r;
		// wake filter: new level must persist for the filter length
		wake_lvl_nxt = wake_lvl_r;
		filt_nxt = '0;
		local_wake = 1'b0;
		if (wake_i != wake_lvl_r)
		begin
			filt_nxt = filt_r + 1'b1;
			if (filt_r >= CNT_W'(FILT_CYC - 1))
			begin
				wake_lvl_nxt = wake_i;
				local_wake = 1'b1;
				filt_nxt = '0;
			end
		end
		// bus monitor stays active in every low-power mode
		wake_ev = low_power(mode_r) & (local_wake | bus_i.bus_dominant);
		mode_nxt = mode_r;
		lock_nxt = lock_r;
		hold_nxt = '0;
		if (supply_i.vbat_uv)
			mode_nxt = CTMC_STANDBY;
		else if (core_uv)
		begin
			mode_nxt = CTMC_SLEEP;
			lock_nxt = 1'b1;
		end
		else if (mode_r == CTMC_SLEEP && wake_ev)
			mode_nxt = CTMC_STANDBY;
		else if (mode_r == CTMC_SLEEP && lock_r)
			mode_nxt = CTMC_SLEEP;
		else
		begin
			case (sel_r)
				2'b11: mode_nxt = CTMC_NORMAL;
				2'b10: mode_nxt = CTMC_LISTEN;
				2'b00: mode_nxt = CTMC_STANDBY;
				2'b01:
				begin
					if (mode_r == CTMC_SLEEP)
						mode_nxt = CTMC_SLEEP;
					else if (wake_ev)
						mode_nxt = CTMC_GOSLEEP;
					else
					begin
						mode_nxt = CTMC_GOSLEEP;
						hold_nxt = hold_r + 1'b1;
						if (hold_r >= CNT_W'(HOLD_CYC))
							mode_nxt = CTMC_SLEEP;
					end
				end
				default: mode_nxt = CTMC_STANDBY;
			endcase
		end
		if (mode_nxt != CTMC_SLEEP)
			lock_nxt = lock_nxt & (mode_nxt == CTMC_SLEEP) | 1'b0;
		if (mode_nxt == CTMC_SLEEP && core_uv)
			lock_nxt = 1'b1;
		// wakeup flag: set wins over the clear on normal entry
		wake_flag_nxt = wake_flag_r;
		if (mode_nxt == CTMC_NORMAL && mode_r != CTMC_NORMAL)
			wake_flag_nxt = 1'b0;
		if (wake_ev)
			wake_flag_nxt = 1'b1;
		pwon_nxt = (mode_nxt == CTMC_LISTEN) ? (mode_r == CTMC_LISTEN ? pwon_r
			: low_power(mode_r)) : 1'b0;
		// count transmit releases after normal entry, dominant periods timed
		txd_q_nxt = txd_i;
		dom_nxt = (!txd_i && dom_r != '1) ? dom_r + 1'b1 : (txd_i ? '0 : dom_r);
		rel_nxt = rel_r;
		if (mode_r != CTMC_NORMAL)
			rel_nxt = '0;
		else if (txd_i && !txd_q_r && dom_r >= CNT_W'(DOM_MIN_CYC) && rel_r < 3'(REL_COUNT))
			rel_nxt = rel_r + 1'b1;
		tx_en_nxt = (mode_nxt == CTMC_NORMAL);
		tx_d_nxt = tx_en_nxt ? txd_i : 1'b1;
		bias_nxt = (mode_nxt == CTMC_NORMAL) || (mode_nxt == CTMC_LISTEN);
		reg_nxt = (mode_nxt != CTMC_SLEEP);
		case (mode_nxt)
			CTMC_NORMAL:
			begin
				rxd_nxt = bus_i.bus_rx;
				fault_nxt = (rel_nxt >= 3'(REL_COUNT)) ? ~bus_i.bus_fail : 1'b1;
			end
			CTMC_LISTEN:
			begin
				rxd_nxt = bus_i.bus_rx;
				fault_nxt = pwon_nxt ? 1'b0 : ~bus_i.local_fail;
			end
			default:
			begin
				rxd_nxt = ~wake_flag_nxt;
				fault_nxt = ~wake_flag_nxt;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			mode_r <= CTMC_STANDBY;
			sel_last_r <= 2'h0;
			sel_r <= 2'h0;
			sel_cnt_r <= '0;
			hold_r <= '0;
			filt_r <= '0;
			dom_r <= '0;
			rel_r <= 3'h0;
			// start from the pin level so a pulled-up wake input gives no false edge
			wake_lvl_r <= wake_i;
			wake_flag_r <= 1'b0;
			lock_r <= 1'b0;
			pwon_r <= 1'b0;
			txd_q_r <= 1'b1;
			tx_enable_o <= 1'b0;
			tx_data_o <= 1'b1;
			rxd_o <= 1'b1;
			fault_flag_out_o <= 1'b1;
			regulator_control_out_o <= 1'b1;
			regulator_control_oe_o <= 1'b1;
			bus_bias_half_o <= 1'b0;
			mode_o <= CTMC_STANDBY;
		end
		else
		begin
			mode_r <= mode_nxt;
			sel_last_r <= sel_last_nxt;
			sel_r <= sel_nxt;
			sel_cnt_r <= sel_cnt_nxt;
			hold_r <= hold_nxt;
			filt_r <= filt_nxt;
			dom_r <= dom_nxt;
			rel_r <= rel_nxt;
			wake_lvl_r <= wake_lvl_nxt;
			wake_flag_r <= wake_flag_nxt;
			lock_r <= lock_nxt;
			pwon_r <= pwon_nxt;
			txd_q_r <= txd_q_nxt;
			tx_enable_o <= tx_en_nxt;
			tx_data_o <= tx_d_nxt;
			rxd_o <= rxd_nxt;
			fault_flag_out_o <= fault_nxt;
			regulator_control_out_o <= reg_nxt;
			regulator_control_oe_o <= reg_nxt;
			bus_bias_half_o <= bias_nxt;
			mode_o <= mode_nxt;
		end
	end

	chk_sleep_floats_reg: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(mode_r == CTMC_SLEEP) |-> !regulator_control_oe_o)
		else $error("regulator output driven in sleep");
	chk_wake_leaves_sleep: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(mode_r == CTMC_SLEEP && bus_i.bus_dominant && !supply_i.vbat_uv && !core_uv)
		|=> (mode_r == CTMC_STANDBY && regulator_control_oe_o))
		else $error("bus wakeup did not leave sleep");
	chk_wake_flag_pins: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(wake_ev && mode_nxt != CTMC_NORMAL && mode_nxt != CTMC_LISTEN)
		|=> (!rxd_o && !fault_flag_out_o))
		else $error("wakeup flag not shown");
	chk_sleep_bus_ground: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(mode_r == CTMC_SLEEP || mode_r == CTMC_STANDBY) |-> !bus_bias_half_o)
		else $error("bus biased in low power");
	chk_gosleep_tx_off: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(mode_r == CTMC_GOSLEEP) |-> !tx_enable_o)
		else $error("transmitter on during sleep command");
	chk_sleep_needs_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(mode_r != CTMC_SLEEP && mode_nxt == CTMC_SLEEP && !core_uv)
		|-> (hold_r >= CNT_W'(HOLD_CYC)))
		else $error("sleep entered early");
	chk_uv_locks_sleep: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(core_uv && !supply_i.vbat_uv) |=> (mode_r == CTMC_SLEEP && lock_r))
		else $error("undervoltage did not force sleep");
	chk_vbat_standby: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		supply_i.vbat_uv |=> (mode_r == CTMC_STANDBY))
		else $error("battery undervoltage not standby");
	chk_listen_no_tx: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(mode_r == CTMC_LISTEN) |-> tx_data_o)
		else $error("transmit passed in listen-only");
	cov_go_sleep: cover property (@(posedge clk_sys_i) mode_r == CTMC_GOSLEEP ##1
		mode_r == CTMC_SLEEP);
	cov_wake_up: cover property (@(posedge clk_sys_i) mode_r == CTMC_SLEEP ##1
		mode_r == CTMC_STANDBY);
	cov_normal_fault: cover property (@(posedge clk_sys_i) mode_r == CTMC_NORMAL &&
		rel_r == 3'(REL_COUNT));
endmodule // ctmc_mode_control

// File: verif/ctmc_host_model.sv
// host controller model: drives the select pair and the transmit line
`timescale 1ns/1ps
module ctmc_host_model
	import ctmc_pkg::*;
#(
	parameter int HOLD_MAX = 12
)(
	input wire logic clk_sys_i,
	input wire ctmc_mode_t cmd_i,
	input wire logic tx_bit_i,
	output logic sel_a_o,
	output logic sel_b_o,
	output logic txd_o
);
	int held_r = 0;
	// sleep command is never dropped before the worst-case hold has passed
	always @(posedge clk_sys_i)
		held_r <= ({sel_a_o, sel_b_o} == 2'h1) ? held_r + 1 : 0;
	always_comb
	begin
		if (cmd_i == CTMC_GOSLEEP || (held_r > 0 && held_r <= HOLD_MAX))
			{sel_a_o, sel_b_o} = 2'h1;
		else if (cmd_i == CTMC_NORMAL)
			{sel_a_o, sel_b_o} = 2'h3;
		else if (cmd_i == CTMC_LISTEN)
			{sel_a_o, sel_b_o} = 2'h2;
		else
			{sel_a_o, sel_b_o} = 2'h0;
	end
	assign txd_o = tx_bit_i;
endmodule // ctmc_host_model

// File: verif/can_transceiver_mode_control_tb.sv
// self-checking bench for the transceiver mode controller
`timescale 1ns/1ps
module can_transceiver_mode_control_tb
	import ctmc_pkg::*;
;
	localparam int HOLD = 8;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic wake_i = 1'b0;
	logic tx_bit = 1'b1;
	ctmc_mode_t cmd = CTMC_STANDBY;
	ctmc_supply_t supply_i = 3'h0;
	ctmc_bus_t bus_i = 4'h4;
	logic sel_a, sel_b, txd, tx_en, tx_dat, rxd, fault, reg_out, reg_oe, bias;
	logic [2:0] mode;
	int err_count = 0;
	int n_checks = 0;
	always #25 clk_sys_i = ~clk_sys_i;
	ctmc_host_model #(.HOLD_MAX(HOLD + 4)) host (.clk_sys_i(clk_sys_i), .cmd_i(cmd),
		.tx_bit_i(tx_bit), .sel_a_o(sel_a), .sel_b_o(sel_b), .txd_o(txd));
	ctmc_mode_control #(.HOLD_CYC(HOLD), .FILT_CYC(4)) dut (.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i), .mode_select_a_i(sel_a), .mode_select_b_i(sel_b),
		.txd_i(txd), .wake_i(wake_i), .supply_i(supply_i), .bus_i(bus_i),
		.tx_enable_o(tx_en), .tx_data_o(tx_dat), .rxd_o(rxd), .fault_flag_out_o(fault),
		.regulator_control_out_o(reg_out), .regulator_control_oe_o(reg_oe),
		.bus_bias_half_o(bias), .mode_o(mode));
	task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	task automatic wait_mode(input ctmc_mode_t m);
		for (int k = 0; k < 40 && mode !== m; k++)
			cyc(1);
		chk(mode, m);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic t_reset();
		chk(mode, CTMC_STANDBY);
		chk({tx_en, tx_dat, bias}, 3'h2);
		chk({rxd, fault, reg_oe}, 3'h7);
		chk(reg_out, 3'h1);
	endtask
	task automatic t_listen_normal();
		cmd = CTMC_LISTEN;
		wait_mode(CTMC_LISTEN);
		cyc(1);
		chk({tx_en, bias, fault}, 3'h2);
		bus_i.bus_rx = 1'b0;
		tx_bit = 1'b0;
		cyc(3);
		chk({rxd, tx_dat, tx_en}, 3'h2);
		tx_bit = 1'b1;
		bus_i = 4'h6;
		cmd = CTMC_NORMAL;
		wait_mode(CTMC_NORMAL);
		cyc(2);
		chk({tx_en, bias, rxd}, 3'h7);
		// dominant pulses just past the minimum length
		for (int p = 1; p <= 4; p++)
		begin
			tx_bit = 1'b0;
			cyc(2);
			chk(tx_dat, 3'h0);
			cyc(DOM_MIN_CYC);
			tx_bit = 1'b1;
			cyc(3);
			chk(fault, (p < 4) ? 3'h1 : 3'h0);
		end
		// listen entered from normal reports the local failure, not power-on
		cmd = CTMC_LISTEN;
		wait_mode(CTMC_LISTEN);
		cyc(1);
		chk(fault, 3'h1);
	endtask
	task automatic t_sleep_bus();
		int k;
		cmd = CTMC_GOSLEEP;
		wait_mode(CTMC_GOSLEEP);
		cyc(1);
		chk({tx_en, bias, reg_oe}, 3'h1);
		chk({rxd, fault}, 3'h3);
		// a wakeup during the command keeps the regulator on and restarts the hold
		bus_i.bus_dominant = 1'b1;
		cyc(HOLD + 2);
		chk(mode, CTMC_GOSLEEP);
		chk({rxd, fault, reg_oe}, 3'h1);
		bus_i.bus_dominant = 1'b0;
		for (k = 0; k < 40 && mode !== CTMC_SLEEP; k++)
			cyc(1);
		chk((k > HOLD) && (k <= HOLD + 4), 3'h1);
		cyc(1);
		chk(reg_oe, 3'h0);
		cyc(5);
		bus_i.bus_dominant = 1'b1;
		cyc(1);
		bus_i.bus_dominant = 1'b0;
		wait_mode(CTMC_STANDBY);
		cmd = CTMC_STANDBY;
		chk({rxd, fault, reg_oe}, 3'h1);
		chk(reg_out, 3'h1);
	endtask
	task automatic t_supply();
		// let the standby request reach the pins before the next command
		cyc(1);
		cmd = CTMC_NORMAL;
		wait_mode(CTMC_NORMAL);
		supply_i.vbat_uv = 1'b1;
		wait_mode(CTMC_STANDBY);
		supply_i.vbat_uv = 1'b0;
		// first pass core supply, second io supply; wake edge alternates
		for (int i = 0; i < 2; i++)
		begin
			cmd = CTMC_NORMAL;
			wait_mode(CTMC_NORMAL);
			supply_i = (i == 0) ? 3'h4 : 3'h2;
			wait_mode(CTMC_SLEEP);
			supply_i = 3'h0;
			cyc(20);
			chk(mode, CTMC_SLEEP);
			cmd = CTMC_STANDBY;
			wake_i = ~wake_i;
			wait_mode(CTMC_STANDBY);
			chk({rxd, fault, reg_oe}, 3'h1);
		end
	endtask
	initial
	begin
		cyc(6);
		sys_rst_i = 1'b0;
		t_reset();
		t_listen_normal();
		t_sleep_bus();
		t_supply();
		finish_test();
	end
	initial
	begin
		#2000000;
		err_count++;
		finish_test();
	end
endmodule // can_transceiver_mode_control_tb
